// *** core/tcm_params.svh ***
// Constants for the timer capture and external match block
`ifndef TCM_PARAMS_SVH
`define TCM_PARAMS_SVH

// Register byte addresses, timer 0 and timer 1
`define TCM_T0_CTRL_ADDR 32'h4000_c028
`define TCM_T0_SNAP_ADDR 32'h4000_c02c
`define TCM_T0_EMR_ADDR  32'h4000_c03c
`define TCM_T1_CTRL_ADDR 32'h4001_0028
`define TCM_T1_SNAP_ADDR 32'h4001_002c
`define TCM_T1_EMR_ADDR  32'h4001_003c

// Snapshot control field positions and width
`define TCM_CC_RISE_BIT  0
`define TCM_CC_FALL_BIT  1
`define TCM_CC_IRQ_BIT   2
`define TCM_CC_W         3

// External match register layout
`define TCM_EMR_W        12
`define TCM_EMR_ACT_LSB  4
`define TCM_CH_N         4
`define TCM_PIN_N        3

// Match actions
`define TCM_ACT_KEEP     2'h0
`define TCM_ACT_CLR      2'h1
`define TCM_ACT_SET      2'h2
`define TCM_ACT_TGL      2'h3

// Reset values
`define TCM_CC_RST       3'h0
`define TCM_SNAP_RST     16'h0000
`define TCM_EMR_RST      12'h000
`define TCM_DATA_RST     32'h0000_0000

// Which match channels own a pin on each timer
`define TCM_T0_PIN_MASK  3'h3
`define TCM_T1_PIN_MASK  3'h7

`endif

// *** core/tcm_pkg.sv ***
// Types shared by the timer capture and external match block
package tcm_pkg;

  // Register selected by an APB address
  typedef enum logic [1:0] {
    TCM_SEL_NONE,
    TCM_SEL_CTRL,
    TCM_SEL_SNAP,
    TCM_SEL_EMR
  } tcm_sel_t;

  // APB answer phase
  typedef enum logic [0:0] {
    TCM_APB_IDLE,
    TCM_APB_ACK
  } tcm_apb_t;

  // Edge detector state
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tcm_sync_t;

  // Whole state of the top module
  typedef struct packed {
    tcm_apb_t    apb_ph;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [2:0]  cc;
    logic [15:0] snap;
    logic [11:0] ext_output_reg;
    logic [3:0]  eq_prev;
    logic        irq;
    logic [2:0]  pin_o;
    logic [2:0]  pin_oe;
  } tcm_state_t;

endpackage

// *** core/tcm_edge_sync.sv ***
// Two-stage synchroniser with rising and falling edge detection
`timescale 1ns/10ps

module tcm_edge_sync (
  input  wire logic sys_clk,   // Timer clock
  input  wire logic sys_rst,   // Synchronous reset, high
  input  wire logic pin_in,    // Asynchronous pin level
  output logic      rise,      // One-cycle pulse on 0 then 1
  output logic      fall       // One-cycle pulse on 1 then 0
);

  tcm_pkg::tcm_sync_t sync_reg;
  tcm_pkg::tcm_sync_t sync_next;

  // ----------------------------------------------------------------
  // Sampling chain
  // ----------------------------------------------------------------
  // Edges are taken from stage two onward; the first stage may be metastable
  always_comb begin
    sync_next      = sync_reg;
    sync_next.meta = pin_in;
    sync_next.sync = sync_reg.meta;
    sync_next.prev = sync_reg.sync;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Successive sampled values compared: one transition, one pulse
  assign rise = sync_reg.sync & ~sync_reg.prev;
  assign fall = ~sync_reg.sync & sync_reg.prev;

endmodule

// *** core/tcm_top.sv ***
// Capture and external match output logic of one 16-bit timer
//
// Behaviour
// - With rise_snapshot_en set, a 0-then-1 on the capture pin loads timer_count into snapshot_reg.
// - With fall_snapshot_en set, a 1-then-0 on the capture pin loads timer_count into snapshot_reg.
// - With both edge enables set, every transition of the capture pin is a capture event.
// - With snapshot_irq_en set, every capture load raises the interrupt.
// - snapshot_reg holds the 16-bit captured count in bits 15:0 and resets to zero.
// - ext_out_state0 always shows match output 0, pinned or not, and resets to 0.
// - On count equal to compare_value0, ext_action0 (bits 5:4) keeps, clears, sets or toggles bit 0.
// - On count equal to compare_value1, ext_action1 (bits 7:6) updates bit 1, reset 0.
// - On count equal to compare_value2, ext_action2 (bits 9:8) updates bit 2, even unpinned.
// - On count equal to compare_value3, ext_action3 (bits 11:10) updates bit 3, never pinned.
// - A pinned match bit drives its pin, 0 low and 1 high, when the pin selects the match function.
// - Timer 1 match bit 2 reaches its pin only when the pin selects the match function.
// - A match pin set for pulse width operation follows the PWM level; ext_out_state still follows the match action.
// - Action codes: 0 keep, 1 clear, 2 set, 3 toggle; each field resets to 00.
// - Each compare value is compared with the count at all times; the first cycle of equality is the match event.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "tcm_params.svh"

module tcm_top #(
  parameter int TIMER_ID = 0                       // 0 or 1, picks addresses and pins
) (
  input  wire logic        sys_clk,                // Timer clock, 25 MHz
  input  wire logic        sys_rst,                // Synchronous reset, high
  input  wire logic        psel,                   // APB select
  input  wire logic        penable,                // APB enable
  input  wire logic        pwrite,                 // APB write
  input  wire logic [31:0] paddr,                  // APB byte address
  input  wire logic [31:0] pwdata,                 // APB write data
  output logic             pready,                 // APB ready, registered
  output logic [31:0]      prdata,                 // APB read data, registered
  output logic             pslverr,                // APB error on unmapped address
  input  wire logic [15:0] timer_count,            // Counter value, same clock
  input  wire logic [15:0] compare_value0,         // Compare register 0
  input  wire logic [15:0] compare_value1,         // Compare register 1
  input  wire logic [15:0] compare_value2,         // Compare register 2
  input  wire logic [15:0] compare_value3,         // Compare register 3
  input  wire logic        snapshot_input_pin,     // Capture pin, asynchronous
  input  wire logic [2:0]  pin_function_config,    // Pin selects match function
  input  wire logic [3:0]  pulse_width_config,     // Channel in PWM operation
  input  wire logic [3:0]  pwm_level,              // Level from PWM logic
  output logic             snapshot_irq,           // Capture interrupt pulse
  output logic [3:0]       ext_out_state,          // Match output bits
  output logic [2:0]       ext_pin_o,              // Match pin level
  output logic [2:0]       ext_pin_oe              // Match pin drive enable
);

  // ----------------------------------------------------------------
  // Elaboration checks and per-timer constants
  // ----------------------------------------------------------------
  if (TIMER_ID != 0 && TIMER_ID != 1) begin : g_bad_id
    $error("tcm_top: TIMER_ID must be 0 or 1");
  end

  localparam logic [31:0] CTRL_ADDR = (TIMER_ID == 0) ? `TCM_T0_CTRL_ADDR : `TCM_T1_CTRL_ADDR;
  localparam logic [31:0] SNAP_ADDR = (TIMER_ID == 0) ? `TCM_T0_SNAP_ADDR : `TCM_T1_SNAP_ADDR;
  localparam logic [31:0] EMR_ADDR  = (TIMER_ID == 0) ? `TCM_T0_EMR_ADDR  : `TCM_T1_EMR_ADDR;
  // Timer 0 has no pin for channel 2; timer 1 pins out channels 0 to 2
  localparam logic [2:0]  PIN_MASK  = (TIMER_ID == 0) ? `TCM_T0_PIN_MASK : `TCM_T1_PIN_MASK;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Address decode, shared by read and write paths
  function automatic tcm_pkg::tcm_sel_t reg_decode(input logic [31:0] addr);
    tcm_pkg::tcm_sel_t sel;
    sel = tcm_pkg::TCM_SEL_NONE;
    if (addr == CTRL_ADDR) begin
      sel = tcm_pkg::TCM_SEL_CTRL;
    end else if (addr == SNAP_ADDR) begin
      sel = tcm_pkg::TCM_SEL_SNAP;
    end else if (addr == EMR_ADDR) begin
      sel = tcm_pkg::TCM_SEL_EMR;
    end
    return sel;
  endfunction

  // Next value of one match bit under a two-bit action code
  function automatic logic match_action(input logic [1:0] act, input logic cur);
    logic res;
    res = cur;
    case (act)
      `TCM_ACT_KEEP: res = cur;
      `TCM_ACT_CLR:  res = 1'b0;
      `TCM_ACT_SET:  res = 1'b1;
      `TCM_ACT_TGL:  res = ~cur;
      default:       res = cur;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Capture pin edges
  // ----------------------------------------------------------------
  logic pin_rise;
  logic pin_fall;

  tcm_edge_sync u_edge (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  (snapshot_input_pin),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // ----------------------------------------------------------------
  // Compare equality
  // ----------------------------------------------------------------
  // Equality is checked every cycle; the action fires on entry only, so a
  // count that dwells on one value under prescaling toggles just once
  logic [3:0]       cmp_eq;
  logic [3:0]       cmp_hit;
  tcm_pkg::tcm_sel_t req_sel;

  assign cmp_eq[0] = (timer_count == compare_value0);
  assign cmp_eq[1] = (timer_count == compare_value1);
  assign cmp_eq[2] = (timer_count == compare_value2);
  assign cmp_eq[3] = (timer_count == compare_value3);
  assign req_sel   = reg_decode(paddr);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tcm_pkg::tcm_state_t st_reg;
  tcm_pkg::tcm_state_t st_next;

  assign cmp_hit = cmp_eq & ~st_reg.eq_prev;

  // Bus, capture and match next-state logic
  always_comb begin
    logic cap_fire;
    cap_fire       = 1'b0;
    st_next        = st_reg;
    st_next.irq    = 1'b0;
    st_next.eq_prev = cmp_eq;

    // APB slave: answers in the first access cycle
    case (st_reg.apb_ph)
      tcm_pkg::TCM_APB_IDLE: begin
        if (psel && !penable) begin
          st_next.apb_ph  = tcm_pkg::TCM_APB_ACK;
          st_next.pready  = 1'b1;
          st_next.pslverr = (req_sel == tcm_pkg::TCM_SEL_NONE);
          st_next.prdata  = `TCM_DATA_RST;
          case (req_sel)
            // Reserved control bits read as zero
            tcm_pkg::TCM_SEL_CTRL: st_next.prdata[`TCM_CC_W-1:0]  = st_reg.cc;
            tcm_pkg::TCM_SEL_SNAP: st_next.prdata[15:0]           = st_reg.snap;
            tcm_pkg::TCM_SEL_EMR:  st_next.prdata[`TCM_EMR_W-1:0] = st_reg.ext_output_reg;
            default:               st_next.prdata = `TCM_DATA_RST;
          endcase
        end
      end
      tcm_pkg::TCM_APB_ACK: begin
        st_next.apb_ph  = tcm_pkg::TCM_APB_IDLE;
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;
        if (psel && penable && pwrite) begin
          case (req_sel)
            tcm_pkg::TCM_SEL_CTRL: st_next.cc  = pwdata[`TCM_CC_W-1:0];
            tcm_pkg::TCM_SEL_EMR:  st_next.ext_output_reg = pwdata[`TCM_EMR_W-1:0];
            default:               st_next.cc  = st_next.cc;  // Snapshot is read-only
          endcase
        end
      end
      default: begin
        st_next.apb_ph = tcm_pkg::TCM_APB_IDLE;
        st_next.pready = 1'b0;
      end
    endcase

    // Capture: either enabled edge, or both when both are set
    if (pin_rise && st_reg.cc[`TCM_CC_RISE_BIT]) begin
      cap_fire = 1'b1;
    end
    if (pin_fall && st_reg.cc[`TCM_CC_FALL_BIT]) begin
      cap_fire = 1'b1;
    end
    if (cap_fire) begin
      st_next.snap = timer_count;
      st_next.irq  = st_reg.cc[`TCM_CC_IRQ_BIT];
    end

    // Match actions win over a software write of the same bit
    for (int i = 0; i < `TCM_CH_N; i++) begin
      if (cmp_hit[i]) begin
        st_next.ext_output_reg[i] = match_action(st_next.ext_output_reg[`TCM_EMR_ACT_LSB + 2*i +: 2],
                                      st_next.ext_output_reg[i]);
      end
    end

    // Pins: PWM level overrides the match bit; drive only when selected
    for (int i = 0; i < `TCM_PIN_N; i++) begin
      st_next.pin_oe[i] = PIN_MASK[i] & pin_function_config[i];
      st_next.pin_o[i]  = pulse_width_config[i] ? pwm_level[i]
                                                : st_next.ext_output_reg[i];
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg         <= '0;
      st_reg.apb_ph  <= tcm_pkg::TCM_APB_IDLE;
      st_reg.cc      <= `TCM_CC_RST;
      st_reg.snap    <= `TCM_SNAP_RST;
      st_reg.ext_output_reg     <= `TCM_EMR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign pready        = st_reg.pready;
  assign prdata        = st_reg.prdata;
  assign pslverr       = st_reg.pslverr;
  assign snapshot_irq  = st_reg.irq;
  // Bit 3 has no pin; it is visible here and in the register only
  assign ext_out_state = st_reg.ext_output_reg[`TCM_CH_N-1:0];
  assign ext_pin_o     = st_reg.pin_o;
  assign ext_pin_oe    = st_reg.pin_oe;

endmodule

// *** dv/tcm_pin_model.sv ***
// Pin-side model: drives the capture pin and resolves the match pads
`timescale 1ns/10ps

module tcm_pin_model (
  input  wire logic       sys_clk, // Timer clock
  input  wire logic       lvl_req, // Capture level asked by the bench
  input  wire logic       slow,    // One extra cycle of lag
  input  wire logic [2:0] pin_o,   // Match pin level
  input  wire logic [2:0] pin_oe,  // Match pin drive enable
  output logic            cap_pin, // Capture pin
  output logic [2:0]      pad      // Resolved pad level
);
  logic       lag_reg;
  logic [2:0] last_reg;

  initial begin
    cap_pin = 1'b0;
    lag_reg = 1'b0;
    last_reg = 3'h0;
  end

  // Pin moves just after an edge, promptly or one cycle late
  always @(posedge sys_clk) begin
    lag_reg <= lvl_req;
    cap_pin <= slow ? lag_reg : lvl_req;
  end

  // No pull on the pads: a released pad shows the inverse of its last level
  always @(posedge sys_clk) last_reg <= pad;
  assign pad = (pin_o & pin_oe) | (~last_reg & ~pin_oe);
endmodule

// *** dv/tcm_top_props.sv ***
// Port checker for the timer capture and match block
`timescale 1ns/10ps
`include "tcm_params.svh"

module tcm_top_props #(
  parameter int TIMER_ID = 0 // As the checked instance
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [15:0] timer_count,
  input wire logic [15:0] compare_value0,
  input wire logic [15:0] compare_value3,
  input wire logic        snapshot_input_pin,
  input wire logic [2:0]  pin_function_config,
  input wire logic [3:0]  pulse_width_config,
  input wire logic [3:0]  pwm_level,
  input wire logic        snapshot_irq,
  input wire logic [3:0]  ext_out_state,
  input wire logic [2:0]  ext_pin_o,
  input wire logic [2:0]  ext_pin_oe
);
  localparam logic [2:0] PIN_MASK = TIMER_ID ? `TCM_T1_PIN_MASK : `TCM_T0_PIN_MASK;
  logic eq0_q;
  logic eq3_q;
  logic wr_now;

  // Equality a cycle ago, so only a rising equality counts as a match
  assign wr_now = psel & penable & pwrite;
  always_ff @(posedge sys_clk) begin
    eq0_q <= !sys_rst && (timer_count == compare_value0);
    eq3_q <= !sys_rst && (timer_count == compare_value3);
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ack;
    pready ##1 !pready;
  endsequence

  property p_ack;
    s_setup |=> s_ack;
  endproperty
  property p_em0;
    !$stable(ext_out_state[0]) && !$past(wr_now) && !$past(sys_rst)
      |-> $past(timer_count == compare_value0 && !eq0_q);
  endproperty
  property p_em3;
    !$stable(ext_out_state[3]) && !$past(wr_now) && !$past(sys_rst)
      |-> $past(timer_count == compare_value3 && !eq3_q);
  endproperty
  property p_hold;
    timer_count == compare_value0 && eq0_q && !wr_now |=> $stable(ext_out_state[0]);
  endproperty
  property p_pin0;
    !$past(pulse_width_config[0]) && ext_pin_oe[0] && !$past(sys_rst)
      |-> ext_pin_o[0] == ext_out_state[0];
  endproperty
  property p_pwm1;
    $past(pulse_width_config[1]) && ext_pin_oe[1] && !$past(sys_rst)
      |-> ext_pin_o[1] == $past(pwm_level[1]);
  endproperty
  property p_oe;
    !$past(sys_rst) |-> ext_pin_oe == ($past(pin_function_config) & PIN_MASK);
  endproperty
  property p_irq;
    snapshot_irq |-> $past(snapshot_input_pin, 3) != $past(snapshot_input_pin, 4);
  endproperty
  property p_irq_one;
    snapshot_irq |=> !snapshot_irq;
  endproperty

  a_ack: assert property (p_ack) else $error("APB answer not one cycle");
  a_em0: assert property (p_em0) else $error("Bit 0 moved without match");
  a_em3: assert property (p_em3) else $error("Bit 3 moved without match");
  a_hold: assert property (p_hold) else $error("Action repeated on held match");
  a_pin0: assert property (p_pin0) else $error("Pin 0 differs from bit 0");
  a_pwm1: assert property (p_pwm1) else $error("Pin 1 ignores PWM level");
  a_oe: assert property (p_oe) else $error("Pin enable wrong");
  a_irq: assert property (p_irq) else $error("Irq without pin edge");
  a_irq_one: assert property (p_irq_one) else $error("Irq longer than a pulse");
endmodule

bind tcm_top tcm_top_props #(.TIMER_ID(TIMER_ID)) chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .timer_count(timer_count), .compare_value0(compare_value0),
  .compare_value3(compare_value3), .snapshot_input_pin(snapshot_input_pin),
  .pin_function_config(pin_function_config), .pulse_width_config(pulse_width_config),
  .pwm_level(pwm_level), .snapshot_irq(snapshot_irq), .ext_out_state(ext_out_state),
  .ext_pin_o(ext_pin_o), .ext_pin_oe(ext_pin_oe));

// *** dv/timer16_capture_match_out_bench.sv ***
// Self-checking bench for the timer capture and match block
`timescale 1ns/10ps
`include "tcm_params.svh"

module timer16_capture_match_out_bench;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd_v;
  logic        pready, pslverr, snapshot_irq, cap_pin, rd_e, lvl_req = 1'b0, slow = 1'b0;
  logic [15:0] timer_count = 16'h0000, cv = 16'h0000, v, snap_exp;
  logic [2:0]  pfc = 3'h0, ext_pin_o, ext_pin_oe, pad;
  logic [3:0]  pwc = 4'h0, pwm = 4'h0, ext_out_state, em_exp;
  logic [7:0]  act;
  int          fails = 0, tests_run = 0, irqs = 0, seed = 61354;

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (snapshot_irq === 1'b1) irqs++;

  // All four compare inputs share one value so every channel fires together
  tcm_top #(.TIMER_ID(1)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_count(timer_count), .compare_value0(cv), .compare_value1(cv),
    .compare_value2(cv), .compare_value3(cv), .snapshot_input_pin(cap_pin),
    .pin_function_config(pfc), .pulse_width_config(pwc), .pwm_level(pwm),
    .snapshot_irq(snapshot_irq), .ext_out_state(ext_out_state), .ext_pin_o(ext_pin_o),
    .ext_pin_oe(ext_pin_oe));
  tcm_pin_model pm_u (.sys_clk(sys_clk), .lvl_req(lvl_req), .slow(slow), .pin_o(ext_pin_o),
    .pin_oe(ext_pin_oe), .cap_pin(cap_pin), .pad(pad));

  // ----------------------------------------
  // Expectation, comparison and bus tasks
  // ----------------------------------------
  function automatic logic [3:0] em_next(logic [3:0] b, logic [7:0] a);
    for (int i = 0; i < 4; i++) begin
      if (a[2*i +: 2] == 2'h1) b[i] = 1'b0;
      else if (a[2*i +: 2] == 2'h2) b[i] = 1'b1;
      else if (a[2*i +: 2] == 2'h3) b[i] = ~b[i];
    end
    return b;
  endfunction

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after an edge; holds the request until pready is sampled high.
  // One idle edge follows, so a second call never reassigns psel in the same step.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_v, exp);
    chk({31'h0, rd_e}, {31'h0, err});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(`TCM_T1_CTRL_ADDR, 32'h0000_0000, 1'b0);
    rd(`TCM_T1_SNAP_ADDR, 32'h0000_0000, 1'b0);
    rd(`TCM_T1_EMR_ADDR, 32'h0000_0000, 1'b0);
    rd(`TCM_T0_CTRL_ADDR, 32'h0000_0000, 1'b1);
    apb(1'b1, `TCM_T1_CTRL_ADDR, 32'hFFFF_FFFF);
    rd(`TCM_T1_CTRL_ADDR, 32'h0000_0007, 1'b0);
    apb(1'b1, `TCM_T1_SNAP_ADDR, 32'h0000_FFFF);
    rd(`TCM_T1_SNAP_ADDR, 32'h0000_0000, 1'b0);
    // Rise only with irq, fall only without, then both edges with irq
    snap_exp = 16'h0000;
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, `TCM_T1_CTRL_ADDR, {29'h0, m != 2, m[1:0]});
      irqs = 0;
      for (int k = 0; k < 4; k++) begin
        timer_count <= $random(seed);
        slow <= $random(seed);
        lvl_req <= ~lvl_req;
        repeat (8) @(posedge sys_clk);
        if (lvl_req ? m[0] : m[1]) snap_exp = timer_count;
        rd(`TCM_T1_SNAP_ADDR, {16'h0000, snap_exp}, 1'b0);
      end
      chk(irqs, (m == 2) ? 0 : m + 1);
    end
    // Random actions; equality held three cycles must act only once
    for (int n = 0; n < 12; n++) begin
      v = $random(seed);
      act = $random(seed);
      em_exp = $random(seed);
      cv <= v;
      timer_count <= ~v;
      pfc <= $random(seed);
      pwc <= $random(seed);
      pwm <= $random(seed);
      apb(1'b1, `TCM_T1_EMR_ADDR, {20'h0_0000, act, em_exp});
      timer_count <= v;
      repeat (3) @(posedge sys_clk);
      timer_count <= ~v;
      repeat (2) @(posedge sys_clk);
      em_exp = em_next(em_exp, act);
      chk(ext_out_state, em_exp);
      chk(ext_pin_oe, pfc & `TCM_T1_PIN_MASK);
      for (int i = 0; i < 3; i++) begin
        if (pfc[i]) chk(pad[i], pwc[i] ? pwm[i] : em_exp[i]);
      end
      rd(`TCM_T1_EMR_ADDR, {20'h0_0000, act, em_exp}, 1'b0);
    end
    test_done();
  end

  // Watchdog well beyond the roughly 300 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    test_done();
  end
endmodule
